// [pkg/dcc_defs.svh]
// Frame layout and timing constants for the charge parameter codec
`ifndef DCC_DEFS_SVH
`define DCC_DEFS_SVH
`define DCC_CLK_HZ        250000000
`define DCC_PERIOD_MS     100
`define DCC_PERIOD_CYC    (`DCC_CLK_HZ / 1000 * `DCC_PERIOD_MS)
// Short frame period so a run stays in a few thousand cycles
`define DCC_SIM_PERIOD_CYC 400
`define DCC_ID_VEH        11'h102
`define DCC_ID_STA_CAP    11'h108
`define DCC_ID_STA_OUT    11'h109
`define DCC_VOLT_MAX      16'h0258
`define DCC_RATE_MAX      8'h64
`define DCC_B4_OVERV      0
`define DCC_B4_UNDERV     1
`define DCC_B4_CURDEV     2
`define DCC_B4_OVERTEMP   3
`define DCC_B4_VOLTDEV    4
`define DCC_B5_ENABLE     0
`define DCC_B5_SHIFT      1
`define DCC_B5_FAULT      2
`define DCC_B5_CONTACT    3
`define DCC_B5_STOPREQ    4
`define DCC_ADDR_STATUS   4'h0
`define DCC_ADDR_MASK     4'h1
`define DCC_ADDR_FLAGS    4'h2
`define DCC_ADDR_RATE     4'h3
`define DCC_ADDR_TARGET   4'h4
`define DCC_ADDR_CAP      4'h5
`define DCC_ADDR_VMAX     4'h6
`define DCC_ADDR_THRESH   4'h7
`define DCC_ADDR_OUTV     4'h8
`define DCC_ADDR_IMAX     4'h9
`define DCC_ADDR_PROTO    4'ha
`define DCC_ST_RX         0
`define DCC_ST_FLAGCHG    1
`define DCC_ST_RANGE      2
`define DCC_ST_W          3
`endif

// [pkg/dcc_pkg.sv]
// Shared types for the charge parameter codec
package dcc_pkg;
    typedef logic [7:0][7:0] dcc_payload_t;
    typedef logic [10:0]     dcc_canid_t;
endpackage

// [pkg/dcc_link_if.sv]
// Frame carrier joining station and vehicle ends
`timescale 1ns/10ps
interface dcc_link_if;
    logic                  staValid;   // Station frame strobe
    dcc_pkg::dcc_canid_t   staId;      // Station frame identifier
    dcc_pkg::dcc_payload_t staData;    // Station frame payload
    logic                  vehValid;   // Vehicle frame strobe
    dcc_pkg::dcc_canid_t   vehId;      // Vehicle frame identifier
    dcc_pkg::dcc_payload_t vehData;    // Vehicle frame payload
    modport station (output staValid, staId, staData,
                     input vehValid, vehId, vehData);
    modport vehicle (input staValid, staId, staData,
                     output vehValid, vehId, vehData);
endinterface

// [core/dcc_station.sv]
// Station end: packs capability frames, unpacks vehicle status frames
//
// Chosen here: the address map and strobed register access.
`include "dcc_defs.svh"
`timescale 1ns/10ps
// Operation
// (R01) Vehicle charging rate in 0x102 byte 6
// (R02) Charge enable flag 0x102 byte5 bit0
// (R03) Shift lever flag 0x102 byte5 bit1
// (R04) System fault flag 0x102 byte5 bit2
// (R05) Contactor status flag 0x102 byte5 bit3
// (R06) Normal stop request 0x102 byte5 bit4
// (R07) Battery overvoltage flag byte4 bit0
// (R08) Battery undervoltage flag byte4 bit1
// (R09) Current deviation flag byte4 bit2
// (R10) Battery overtemperature flag byte4 bit3
// (R11) Voltage deviation flag byte4 bit4
// (R12) Welding support byte 0x108.0 every 100ms
// (R13) Max output voltage 0x108 bytes 1-2
// (R14) Max output current 0x108 byte 3
// (R15) Threshold voltage 0x108 bytes 4-5
// (R16) Protocol number 0x109 byte 0
// (R17) Measured output voltage 0x109 bytes 1-2
// (R18) Target voltage 0x102 bytes 1-2
// (R19) One build-time byte order for pairs
module dcc_station #(
    parameter bit          LSB_FIRST  = 1'b1,
    parameter int unsigned PERIOD_CYC = `DCC_PERIOD_CYC
) (
    input  wire logic        ref_clk,   // System clock 250 MHz
    input  wire logic        rst,       // Async reset, high
    dcc_link_if.station      link,      // Frame link to vehicle
    input  wire logic [3:0]  regAddr,   // Register address
    input  wire logic [15:0] regWdata,  // Register write data
    input  wire logic        regWr,     // Write strobe
    input  wire logic        regRd,     // Read strobe
    output logic      [15:0] regRdata,  // Read data, next cycle
    output logic             irq        // Level interrupt
);
    ////////////////////////////////////////////////////////////////////
    logic [31:0] tick_reg;
    logic        phase_reg;
    logic [7:0]  weldSup_reg;
    logic [15:0] vMax_reg;
    logic [7:0]  iMax_reg;
    logic [15:0] thresh_reg;
    logic [7:0]  proto_reg;
    logic [15:0] outV_reg;
    logic [3:0]  status_reg;
    logic [3:0]  mask_reg;
    logic [4:0]  fl4_reg;
    logic [4:0]  fl5_reg;
    logic [7:0]  rate_reg;
    logic [15:0] target_reg;
    logic        rxFrame;
    logic        flagChg;
    logic        rangeErr;
    logic        wrDone;
    logic [15:0] rxTarget;
    logic [3:0]  evt;
    logic [3:0]  status_next;

    // Pack a 16-bit quantity into two bytes
    function automatic logic [15:0] packPair(input logic [15:0] v);
        // (R19) Fixed pair order
        packPair = LSB_FIRST ? v : {v[7:0], v[15:8]};
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Period tick; the two frames alternate so each one repeats at 100 ms
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tick_reg  <= 32'h0;
            phase_reg <= 1'b0;
        end else if (tick_reg == 32'((PERIOD_CYC / 2) - 1)) begin
            tick_reg  <= 32'h0;
            phase_reg <= ~phase_reg;
        end else begin
            tick_reg <= tick_reg + 32'h1;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            link.staValid <= 1'b0;
            link.staId    <= 11'h0;
            link.staData  <= '0;
        end else if (tick_reg == 32'((PERIOD_CYC / 2) - 1)) begin
            link.staValid <= 1'b1;
            link.staData  <= '0;
            if (!phase_reg) begin
                link.staId      <= `DCC_ID_STA_CAP;
                // (R12) Welding support byte
                link.staData[0] <= weldSup_reg;
                // (R13) Available voltage pair
                {link.staData[2], link.staData[1]} <= packPair(vMax_reg);
                // (R14) Available current
                link.staData[3] <= iMax_reg;
                // (R15) Threshold voltage pair
                {link.staData[5], link.staData[4]} <= packPair(thresh_reg);
            end else begin
                link.staId      <= `DCC_ID_STA_OUT;
                // (R16) Protocol number
                link.staData[0] <= proto_reg;
                // (R17) Output voltage pair
                {link.staData[2], link.staData[1]} <= packPair(outV_reg);
            end
        end else begin
            link.staValid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    assign rxFrame  = link.vehValid && (link.vehId == `DCC_ID_VEH);
    // (R18) Target pair unpack
    assign rxTarget = packPair({link.vehData[2], link.vehData[1]});
    assign flagChg  = rxFrame && ({link.vehData[4][4:0],
                      link.vehData[5][4:0]} != {fl4_reg, fl5_reg});
    // Out of range values are flagged but still stored as received
    assign rangeErr = rxFrame && ((link.vehData[6] > `DCC_RATE_MAX)
                      || (rxTarget > `DCC_VOLT_MAX));
    assign wrDone   = regWr && (regAddr <= `DCC_ADDR_PROTO)
                      && (regAddr >= `DCC_ADDR_CAP);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            fl4_reg    <= 5'h0;
            fl5_reg    <= 5'h0;
            rate_reg   <= 8'h0;
            target_reg <= 16'h0;
        end else if (rxFrame) begin
            // (R01) Charging rate byte
            rate_reg   <= link.vehData[6];
            // (R02) Status byte 5 flags
            // (R03) (R04) (R05) (R06) Same byte
            fl5_reg    <= link.vehData[5][4:0];
            // (R07) Fault byte 4 flags
            // (R08) (R09) (R10) (R11) Same byte
            fl4_reg    <= link.vehData[4][4:0];
            target_reg <= rxTarget;
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            weldSup_reg <= 8'h0;
            vMax_reg    <= 16'h0;
            iMax_reg    <= 8'h0;
            thresh_reg  <= 16'h0;
            proto_reg   <= 8'h0;
            outV_reg    <= 16'h0;
            mask_reg    <= 4'h0;
        end else if (regWr) begin
            unique case (regAddr)
                `DCC_ADDR_MASK:   mask_reg    <= regWdata[3:0];
                `DCC_ADDR_CAP:    weldSup_reg <= regWdata[7:0];
                `DCC_ADDR_VMAX:   vMax_reg    <= regWdata;
                `DCC_ADDR_THRESH: thresh_reg  <= regWdata;
                `DCC_ADDR_OUTV:   outV_reg    <= regWdata;
                `DCC_ADDR_IMAX:   iMax_reg    <= regWdata[7:0];
                `DCC_ADDR_PROTO:  proto_reg   <= regWdata[7:0];
                default: ;
            endcase
        end
    end

    // Sticky events; a new event in the clearing read cycle survives
    always_comb begin
        evt = 4'h0;
        evt[`DCC_ST_RX]      = rxFrame;
        evt[`DCC_ST_FLAGCHG] = flagChg;
        evt[`DCC_ST_RANGE]   = rangeErr;
        evt[`DCC_ST_W]       = wrDone;
        status_next = status_reg;
        if (regRd && regAddr == `DCC_ADDR_STATUS) begin
            status_next = 4'h0;
        end
        status_next = status_next | evt;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            status_reg <= 4'h0;
            irq        <= 1'b0;
        end else begin
            status_reg <= status_next;
            irq        <= |(status_next & mask_reg);
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            regRdata <= 16'h0;
        end else if (regRd) begin
            unique case (regAddr)
                `DCC_ADDR_STATUS: regRdata <= {12'h0, status_reg};
                `DCC_ADDR_MASK:   regRdata <= {12'h0, mask_reg};
                `DCC_ADDR_FLAGS:  regRdata <= {3'h0, fl4_reg, 3'h0, fl5_reg};
                `DCC_ADDR_RATE:   regRdata <= {8'h0, rate_reg};
                `DCC_ADDR_TARGET: regRdata <= target_reg;
                `DCC_ADDR_CAP:    regRdata <= {8'h0, weldSup_reg};
                `DCC_ADDR_VMAX:   regRdata <= vMax_reg;
                `DCC_ADDR_THRESH: regRdata <= thresh_reg;
                `DCC_ADDR_OUTV:   regRdata <= outV_reg;
                `DCC_ADDR_IMAX:   regRdata <= {8'h0, iMax_reg};
                `DCC_ADDR_PROTO:  regRdata <= {8'h0, proto_reg};
                default:          regRdata <= 16'h0;
            endcase
        end else begin
            regRdata <= 16'h0;
        end
    end
endmodule // dcc_station

// [core/dcc_vehicle.sv]
// Vehicle end: packs status frame, unpacks station frames
`include "dcc_defs.svh"
`timescale 1ns/10ps
module dcc_vehicle #(
    parameter bit          LSB_FIRST  = 1'b1,
    parameter int unsigned PERIOD_CYC = `DCC_PERIOD_CYC
) (
    input  wire logic        ref_clk,     // System clock 250 MHz
    input  wire logic        rst,         // Async reset, high
    dcc_link_if.vehicle      link,        // Frame link to station
    input  wire logic [7:0]  chgRate,     // Charging rate, 1 %/bit
    input  wire logic [15:0] targetVolt,  // Target voltage, 1 V/bit
    input  wire logic [4:0]  statusFlags, // Byte 5 flags
    input  wire logic [4:0]  faultFlags,  // Byte 4 flags
    output logic      [7:0]  weldSup,     // Station welding support
    output logic      [15:0] availVolt,   // Station max voltage
    output logic      [7:0]  availCurr,   // Station max current
    output logic      [15:0] threshVolt,  // Station threshold
    output logic      [7:0]  protoNum,    // Station protocol number
    output logic      [15:0] outVolt,     // Station output voltage
    output logic             staUpdate    // Pulse on station frame
);
    logic [31:0] tick_reg;
    logic [15:0] tgt;

    // (R19) Fixed pair order
    assign tgt = LSB_FIRST ? targetVolt : {targetVolt[7:0], targetVolt[15:8]};

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            tick_reg      <= 32'h0;
            link.vehValid <= 1'b0;
            link.vehId    <= 11'h0;
            link.vehData  <= '0;
        end else if (tick_reg == 32'(PERIOD_CYC - 1)) begin
            tick_reg      <= 32'h0;
            link.vehValid <= 1'b1;
            link.vehId    <= `DCC_ID_VEH;
            link.vehData  <= '0;
            // (R18) Target voltage pair
            {link.vehData[2], link.vehData[1]} <= tgt;
            // (R07) Fault flags byte 4
            // (R08) (R09) (R10) (R11) Same byte
            link.vehData[4][4:0] <= faultFlags;
            // (R02) Status flags byte 5
            // (R03) (R04) (R05) (R06) Same byte
            link.vehData[5][4:0] <= statusFlags;
            // (R01) Charging rate byte
            link.vehData[6] <= chgRate;
        end else begin
            tick_reg      <= tick_reg + 32'h1;
            link.vehValid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            weldSup    <= 8'h0;
            availVolt  <= 16'h0;
            availCurr  <= 8'h0;
            threshVolt <= 16'h0;
            protoNum   <= 8'h0;
            outVolt    <= 16'h0;
            staUpdate  <= 1'b0;
        end else begin
            staUpdate <= link.staValid && (link.staId == `DCC_ID_STA_CAP
                         || link.staId == `DCC_ID_STA_OUT);
            if (link.staValid && link.staId == `DCC_ID_STA_CAP) begin
                // (R12) Welding support
                weldSup    <= link.staData[0];
                // (R13) Available voltage
                availVolt  <= LSB_FIRST ?
                    {link.staData[2], link.staData[1]} :
                    {link.staData[1], link.staData[2]};
                // (R14) Available current
                availCurr  <= link.staData[3];
                // (R15) Threshold voltage
                threshVolt <= LSB_FIRST ?
                    {link.staData[5], link.staData[4]} :
                    {link.staData[4], link.staData[5]};
            end
            if (link.staValid && link.staId == `DCC_ID_STA_OUT) begin
                // (R16) Protocol number
                protoNum <= link.staData[0];
                // (R17) Output voltage
                outVolt  <= LSB_FIRST ?
                    {link.staData[2], link.staData[1]} :
                    {link.staData[1], link.staData[2]};
            end
        end
    end
endmodule // dcc_vehicle

// [testbench/dcc_link_checker.sv]
// Link-level assertions for the charge parameter codec
`include "dcc_defs.svh"
`timescale 1ns/10ps
module dcc_link_checker #(
    parameter int PERIOD_CYC = `DCC_PERIOD_CYC
) (
    input wire logic                  ref_clk,  // System clock
    input wire logic                  rst,      // Async reset, high
    input wire logic                  staValid, // Station strobe
    input wire dcc_pkg::dcc_canid_t   staId,    // Station id
    input wire dcc_pkg::dcc_payload_t staData,  // Station payload
    input wire logic                  vehValid, // Vehicle strobe
    input wire dcc_pkg::dcc_canid_t   vehId,    // Vehicle id
    input wire dcc_pkg::dcc_payload_t vehData   // Vehicle payload
);
    localparam int HALF = PERIOD_CYC / 2;
    localparam int FULL = PERIOD_CYC;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    int unsigned         staCnt_reg;
    int unsigned         vehCnt_reg;
    logic                staSeen_reg;
    logic                vehSeen_reg;
    dcc_pkg::dcc_canid_t lastId_reg;
    ////////////////////////////////////////////////////////////////////////
    // Counters run from reset so the first frame only arms the spacing check
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            staCnt_reg <= 0;
            staSeen_reg <= 1'b0;
            lastId_reg <= `DCC_ID_STA_OUT;
        end else if (staValid) begin
            staCnt_reg <= 0;
            staSeen_reg <= 1'b1;
            lastId_reg <= staId;
        end else begin
            staCnt_reg <= staCnt_reg + 1;
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            vehCnt_reg <= 0;
            vehSeen_reg <= 1'b0;
        end else if (vehValid) begin
            vehCnt_reg <= 0;
            vehSeen_reg <= 1'b1;
        end else begin
            vehCnt_reg <= vehCnt_reg + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    property p_sta_pulse; staValid |=> !staValid; endproperty
    property p_sta_ids;
        staValid |-> (staId == `DCC_ID_STA_CAP || staId == `DCC_ID_STA_OUT);
    endproperty
    property p_sta_alt; staValid |-> staId != lastId_reg; endproperty
    property p_sta_gap;
        staValid && staSeen_reg |-> staCnt_reg >= HALF - 2;
    endproperty
    property p_sta_late; staSeen_reg |-> staCnt_reg <= HALF; endproperty
    property p_sta_hold;
        !staValid |-> $stable(staId) && $stable(staData);
    endproperty
    property p_veh_pulse; vehValid |=> !vehValid; endproperty
    property p_veh_id; vehValid |-> vehId == `DCC_ID_VEH; endproperty
    property p_veh_gap; vehSeen_reg |-> vehCnt_reg <= FULL; endproperty
    property p_veh_hold; !vehValid |-> $stable(vehData); endproperty
    a_sta_pulse: assert property (p_sta_pulse)
        else $error("station strobe longer than one cycle");
    a_sta_ids: assert property (p_sta_ids)
        else $error("station frame id unexpected");
    a_sta_alt: assert property (p_sta_alt)
        else $error("station frames do not alternate");
    a_sta_gap: assert property (p_sta_gap)
        else $error("station frames too close");
    a_sta_late: assert property (p_sta_late)
        else $error("station frame overdue");
    a_sta_hold: assert property (p_sta_hold)
        else $error("station frame changed between strobes");
    a_veh_pulse: assert property (p_veh_pulse)
        else $error("vehicle strobe longer than one cycle");
    a_veh_id: assert property (p_veh_id)
        else $error("vehicle frame id unexpected");
    a_veh_gap: assert property (p_veh_gap)
        else $error("vehicle frame overdue");
    a_veh_hold: assert property (p_veh_hold)
        else $error("vehicle frame changed between strobes");
    c_cap: cover property (staValid && staId == `DCC_ID_STA_CAP);
    c_out: cover property (staValid && staId == `DCC_ID_STA_OUT);
    c_veh: cover property (vehValid);
endmodule // dcc_link_checker

// [testbench/test_dc_charge_can_param_codec.sv]
// Bench joining station and vehicle ends over the frame link
`include "dcc_defs.svh"
`timescale 1ns/10ps
module test_dc_charge_can_param_codec;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  regAddr = 4'h0;
    logic [15:0] regWdata = 16'h0000;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [15:0] regRdata;
    logic        irq;
    logic [7:0]  chgRate = 8'h65;
    logic [15:0] targetVolt = 16'h0190;
    logic [4:0]  statusFlags = 5'h15;
    logic [4:0]  faultFlags = 5'h0a;
    logic [7:0]  weldSup, availCurr, protoNum;
    logic [15:0] availVolt, threshVolt, outVolt;
    logic        staUpdate;
    logic [15:0] regRdataMsb, availVoltMsb, threshVoltMsb, outVoltMsb;
    logic        irqMsb;
    int          fails = 0;
    int          num_checks = 0;
    always #2 ref_clk = ~ref_clk;
    dcc_link_if dcc_link_if_inst ();
    dcc_station #(.PERIOD_CYC(`DCC_SIM_PERIOD_CYC)) dcc_station_inst (
        .ref_clk(ref_clk), .rst(rst),
        .link(dcc_link_if_inst), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .irq(irq));
    dcc_vehicle #(.PERIOD_CYC(`DCC_SIM_PERIOD_CYC)) dcc_vehicle_inst (
        .ref_clk(ref_clk), .rst(rst),
        .link(dcc_link_if_inst), .chgRate(chgRate), .targetVolt(targetVolt),
        .statusFlags(statusFlags), .faultFlags(faultFlags),
        .weldSup(weldSup), .availVolt(availVolt), .availCurr(availCurr),
        .threshVolt(threshVolt), .protoNum(protoNum), .outVolt(outVolt),
        .staUpdate(staUpdate));
    // Second pair shares the register bus and runs high byte first
    dcc_link_if msbLink ();
    dcc_station #(.LSB_FIRST(1'b0), .PERIOD_CYC(`DCC_SIM_PERIOD_CYC))
        dcc_station_msb_inst (.ref_clk(ref_clk), .rst(rst), .link(msbLink),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
        .regRd(regRd), .regRdata(regRdataMsb), .irq(irqMsb));
    dcc_vehicle #(.LSB_FIRST(1'b0), .PERIOD_CYC(`DCC_SIM_PERIOD_CYC))
        dcc_vehicle_msb_inst (.ref_clk(ref_clk), .rst(rst), .link(msbLink),
        .chgRate(chgRate), .targetVolt(targetVolt),
        .statusFlags(statusFlags), .faultFlags(faultFlags),
        .weldSup(), .availVolt(availVoltMsb), .availCurr(),
        .threshVolt(threshVoltMsb), .protoNum(), .outVolt(outVoltMsb),
        .staUpdate());
    dcc_link_checker #(.PERIOD_CYC(`DCC_SIM_PERIOD_CYC))
        dcc_link_checker_inst (.ref_clk(ref_clk), .rst(rst),
        .staValid(dcc_link_if_inst.staValid), .staId(dcc_link_if_inst.staId),
        .staData(dcc_link_if_inst.staData),
        .vehValid(dcc_link_if_inst.vehValid), .vehId(dcc_link_if_inst.vehId),
        .vehData(dcc_link_if_inst.vehData));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk16(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1 chk16("regRdata", exp, regRdata);
        chk16("regRdataMsb", exp, regRdataMsb);
    endtask
    // Bounded wait for a one-cycle strobe, returns just after its edge
    task automatic wait_hi(input int which);
        for (int i = 0; i < 2 * `DCC_SIM_PERIOD_CYC; i++) begin
            @(posedge ref_clk);
            #1;
            if (which == 0 && dcc_link_if_inst.staValid === 1'b1) return;
            if (which == 1 && dcc_link_if_inst.vehValid === 1'b1) return;
        end
        fails++;
        $display("BAD strobe wait expected 1 seen 0");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (10 * `DCC_SIM_PERIOD_CYC) @(posedge ref_clk);
        fails++;
        summarize();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        wr(`DCC_ADDR_MASK, 16'h0001);
        wr(`DCC_ADDR_CAP, 16'h0001);
        wr(`DCC_ADDR_VMAX, `DCC_VOLT_MAX);
        wr(`DCC_ADDR_THRESH, 16'h01f4);
        wr(`DCC_ADDR_OUTV, 16'h0190);
        wr(`DCC_ADDR_IMAX, 16'h00ff);
        wr(`DCC_ADDR_PROTO, 16'h0002);
        wr(`DCC_ADDR_RATE, 16'h0033);
        rd(`DCC_ADDR_VMAX, 16'h0258);
        rd(`DCC_ADDR_IMAX, 16'h00ff);
        rd(`DCC_ADDR_RATE, 16'h0000);
        rd(4'hf, 16'h0000);
        chk16("irq", 16'h0000, 16'(irq));
        rd(`DCC_ADDR_STATUS, 16'h0008);
        rd(`DCC_ADDR_STATUS, 16'h0000);
        fork
            begin
                wait_hi(0);
                chk16("staId", 16'h0108, 16'(dcc_link_if_inst.staId));
                chk16("b0", 16'h0001, 16'(dcc_link_if_inst.staData[0]));
                chk16("b1", 16'h0058, 16'(dcc_link_if_inst.staData[1]));
                chk16("b2", 16'h0002, 16'(dcc_link_if_inst.staData[2]));
                chk16("b3", 16'h00ff, 16'(dcc_link_if_inst.staData[3]));
                chk16("b4", 16'h00f4, 16'(dcc_link_if_inst.staData[4]));
                chk16("b5", 16'h0001, 16'(dcc_link_if_inst.staData[5]));
                chk16("m1", 16'h0002, 16'(msbLink.staData[1]));
                chk16("m2", 16'h0058, 16'(msbLink.staData[2]));
                @(posedge ref_clk);
                #1 chk16("staUpdate", 16'h0001, 16'(staUpdate));
                chk16("weldSup", 16'h0001, 16'(weldSup));
                chk16("availVolt", 16'h0258, availVolt);
                chk16("availCurr", 16'h00ff, 16'(availCurr));
                chk16("threshVolt", 16'h01f4, threshVolt);
                chk16("availVoltMsb", 16'h0258, availVoltMsb);
                chk16("threshVoltMsb", 16'h01f4, threshVoltMsb);
                wait_hi(0);
                chk16("staId", 16'h0109, 16'(dcc_link_if_inst.staId));
                chk16("b0", 16'h0002, 16'(dcc_link_if_inst.staData[0]));
                chk16("b1", 16'h0090, 16'(dcc_link_if_inst.staData[1]));
                chk16("b2", 16'h0001, 16'(dcc_link_if_inst.staData[2]));
                @(posedge ref_clk);
                #1 chk16("protoNum", 16'h0002, 16'(protoNum));
                chk16("outVolt", 16'h0190, outVolt);
                chk16("outVoltMsb", 16'h0190, outVoltMsb);
            end
            begin
                wait_hi(1);
                chk16("vehId", 16'h0102, 16'(dcc_link_if_inst.vehId));
                chk16("v1", 16'h0090, 16'(dcc_link_if_inst.vehData[1]));
                chk16("v2", 16'h0001, 16'(dcc_link_if_inst.vehData[2]));
                chk16("v4", 16'h000a, 16'(dcc_link_if_inst.vehData[4]));
                chk16("v5", 16'h0015, 16'(dcc_link_if_inst.vehData[5]));
                chk16("v6", 16'h0065, 16'(dcc_link_if_inst.vehData[6]));
                chk16("mv1", 16'h0001, 16'(msbLink.vehData[1]));
                chk16("mv2", 16'h0090, 16'(msbLink.vehData[2]));
                @(posedge ref_clk);
                #1 chk16("irq", 16'h0001, 16'(irq));
                chk16("irqMsb", 16'h0001, 16'(irqMsb));
                rd(`DCC_ADDR_RATE, 16'h0065);
                rd(`DCC_ADDR_TARGET, 16'h0190);
                rd(`DCC_ADDR_FLAGS, 16'h0a15);
                rd(`DCC_ADDR_STATUS, 16'h0007);
                chk16("irq", 16'h0000, 16'(irq));
            end
        join
        summarize();
    end
endmodule // test_dc_charge_can_param_codec
